// ==== fisc_consts.svh ====
`ifndef FISC_CONSTS_SVH
`define FISC_CONSTS_SVH

// ==========================================================================
// register byte offsets on the axi4-lite port
`define FISC_OFS_ADDR_HIGH 8'h00
`define FISC_OFS_ADDR_LOW 8'h04
`define FISC_OFS_WRITE_DATA 8'h08
`define FISC_OFS_READ_DATA 8'h0c
`define FISC_OFS_COUNT 8'h10
`define FISC_OFS_XPTR 8'h14
`define FISC_OFS_SEGMENT 8'h18
`define FISC_OFS_ACCUM 8'h1c
`define FISC_OFS_COMMAND 8'h20
`define FISC_OFS_STATUS 8'h24

// ==========================================================================
// status register fields
`define FISC_ST_BUSY 0
`define FISC_ST_ERR 1

// ==========================================================================
// command entry-point codes
`define FISC_CMD_READ_BYTE 8'h11
`define FISC_CMD_WRITE_BYTE 8'h14
`define FISC_CMD_BLOCK_READ 8'h26
`define FISC_CMD_BLOCK_WRITE 8'h23
`define FISC_CMD_MASS_ERASE 8'h1a
`define FISC_CMD_EXIT 8'h62

// ==========================================================================
// values and limits
`define FISC_ERASE_KEY 8'h55
`define FISC_BLOCK_WRITE_MAX 8'h10
`define FISC_ERASED_BYTE 8'hff
`define FISC_RESP_OKAY 2'b00
`define FISC_RESP_SLVERR 2'b10

// ==========================================================================
// timing: byte program time and its cycle count at the 20 mhz clock
`define FISC_CLK_MHZ 20
`define FISC_PROG_TIME_NS 1000
`define FISC_PROG_CYCLES ((`FISC_PROG_TIME_NS * `FISC_CLK_MHZ + 999) / 1000)

`endif

// ==== fisc_pkg.sv ====
`default_nettype none

package fisc_pkg;

  // sequencer states, one-hot
  typedef enum logic [6:0] {
    FISC_S_IDLE  = 7'b0000001,
    FISC_S_FETCH = 7'b0000010,
    FISC_S_STORE = 7'b0000100,
    FISC_S_LOAD  = 7'b0001000,
    FISC_S_GRAB  = 7'b0010000,
    FISC_S_PROG  = 7'b0100000,
    FISC_S_ERASE = 7'b1000000
  } fisc_state_t;

endpackage

`default_nettype wire

// ==== fisc_flash_mem.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// flash byte array, registered read data
module fisc_flash_mem #(
  parameter int DEPTH = 8192,
  parameter int AW = 13
) (
  // clock
  input wire logic aclk,
  // access
  input wire logic re,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [DEPTH];

  // write port
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // read port
  always_ff @(posedge aclk) begin
    if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule

`default_nettype wire

// ==== fisc_prog_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// one-cycle enable after CYCLES clocks of run
module fisc_prog_timer #(
  parameter int CYCLES = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  output logic tick
);

  logic [15:0] cnt_q;

  // counts while run is high, restarts when it drops
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_q == 16'(CYCLES - 1)) begin
      cnt_q <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== fisc_isp_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fisc_consts.svh"

// Behaviour
// - address high/low registers form target address
// - read byte fetches flash into read register
// - write byte programs write-data register byte
// - block read moves exactly count bytes, 0-255
// - block read stores to ram from x pointer
// - block write programs count bytes, 0-16
// - block write sources ram from x pointer
// - mass erase only with key 0x55
// - exit command requests device reset
module fisc_isp_unit
  import fisc_pkg::*;
#(
  parameter int FLASH_DEPTH = 8192,
  parameter int FLASH_AW = 13
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // data ram port, read data one cycle after ram_re
  output logic [15:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ram_we,
  output logic ram_re,
  input wire logic [7:0] ram_rdata,
  // status and system
  output logic busy,
  output logic sys_reset_req
);

  // ========================================================================
  // declarations
  fisc_state_t state_q;
  logic [7:0] flash_addr_high_q, flash_addr_low_q, write_data_byte_q;
  logic [7:0] read_data_byte_q, transfer_count_q, xptr_q, segment_q;
  logic [7:0] accum_q, cnt_q, ptr_q;
  logic [FLASH_AW-1:0] fa_q;
  logic [7:0] cmd_q, fl_wdata_q, fl_rdata;
  logic fl_we_q, err_q, aw_hold_q, w_hold_q;
  logic [7:0] awaddr_q, wbyte_q;
  logic wstrb0_q;
  logic do_write, cmd_go, cmd_refused, bad_cmd, err_clr, prog_tick;
  logic [7:0] rd_mux;
  logic rd_ok;

  // ========================================================================
  // axi4-lite write channels
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign cmd_go = do_write && wstrb0_q && (awaddr_q == `FISC_OFS_COMMAND)
                  && !busy;
  assign cmd_refused = do_write && (awaddr_q == `FISC_OFS_COMMAND) && busy;
  assign err_clr = do_write && wstrb0_q && (awaddr_q == `FISC_OFS_STATUS)
                   && wbyte_q[`FISC_ST_ERR];

  // address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_hold_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
    end else if (!aw_hold_q && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  // data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_hold_q <= 1'b0;
      wbyte_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_hold_q <= 1'b1;
      wbyte_q <= s_axi_wdata[7:0];
      wstrb0_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_hold_q <= 1'b0;
    end else if (!w_hold_q && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response: unmapped offsets and commands while busy answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FISC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (cmd_refused || awaddr_q > `FISC_OFS_STATUS ||
                      awaddr_q[1:0] != 2'b00) ?
                     `FISC_RESP_SLVERR : `FISC_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // parameter registers, written by software only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_addr_high_q <= 8'h00;
      flash_addr_low_q <= 8'h00;
      write_data_byte_q <= 8'h00;
      transfer_count_q <= 8'h00;
      xptr_q <= 8'h00;
      segment_q <= 8'h00;
      accum_q <= 8'h00;
    end else if (do_write && wstrb0_q) begin
      unique case (awaddr_q)
        `FISC_OFS_ADDR_HIGH: flash_addr_high_q <= wbyte_q;
        `FISC_OFS_ADDR_LOW: flash_addr_low_q <= wbyte_q;
        `FISC_OFS_WRITE_DATA: write_data_byte_q <= wbyte_q;
        `FISC_OFS_COUNT: transfer_count_q <= wbyte_q;
        `FISC_OFS_XPTR: xptr_q <= wbyte_q;
        `FISC_OFS_SEGMENT: segment_q <= wbyte_q;
        `FISC_OFS_ACCUM: accum_q <= wbyte_q;
        default: ;
      endcase
    end
  end

  // ========================================================================
  // axi4-lite read channels
  always_comb begin
    rd_ok = 1'b1;
    rd_mux = 8'h00;
    unique case (s_axi_araddr)
      `FISC_OFS_ADDR_HIGH: rd_mux = flash_addr_high_q;
      `FISC_OFS_ADDR_LOW: rd_mux = flash_addr_low_q;
      `FISC_OFS_WRITE_DATA: rd_mux = write_data_byte_q;
      `FISC_OFS_READ_DATA: rd_mux = read_data_byte_q;
      `FISC_OFS_COUNT: rd_mux = transfer_count_q;
      `FISC_OFS_XPTR: rd_mux = xptr_q;
      `FISC_OFS_SEGMENT: rd_mux = segment_q;
      `FISC_OFS_ACCUM: rd_mux = accum_q;
      `FISC_OFS_COMMAND: rd_mux = cmd_q;
      `FISC_OFS_STATUS: rd_mux = {6'h00, err_q, busy};
      default: rd_ok = 1'b0;
    endcase
  end

  // read address taken, data registered on the same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FISC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_mux};
      s_axi_rresp <= rd_ok ? `FISC_RESP_OKAY : `FISC_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ========================================================================
  // command sequencer
  assign bad_cmd =
    (wbyte_q == `FISC_CMD_BLOCK_WRITE &&
     transfer_count_q > `FISC_BLOCK_WRITE_MAX) ||
    (wbyte_q == `FISC_CMD_MASS_ERASE && accum_q != `FISC_ERASE_KEY) ||
    !(wbyte_q == `FISC_CMD_READ_BYTE || wbyte_q == `FISC_CMD_WRITE_BYTE ||
      wbyte_q == `FISC_CMD_BLOCK_READ || wbyte_q == `FISC_CMD_BLOCK_WRITE ||
      wbyte_q == `FISC_CMD_MASS_ERASE || wbyte_q == `FISC_CMD_EXIT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= FISC_S_IDLE;
      cmd_q <= 8'h00;
      fa_q <= '0;
      cnt_q <= 8'h00;
      ptr_q <= 8'h00;
      fl_we_q <= 1'b0;
      fl_wdata_q <= 8'h00;
      read_data_byte_q <= 8'h00;
      ram_addr <= 16'h0000;
      ram_wdata <= 8'h00;
      ram_we <= 1'b0;
      ram_re <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      fl_we_q <= 1'b0;
      ram_we <= 1'b0;
      ram_re <= 1'b0;
      sys_reset_req <= 1'b0;
      unique case (state_q)
        FISC_S_IDLE: begin
          if (cmd_go && !bad_cmd) begin
            cmd_q <= wbyte_q;
            fa_q <= FLASH_AW'({flash_addr_high_q,
                               flash_addr_low_q});
            cnt_q <= transfer_count_q;
            ptr_q <= xptr_q;
            if (wbyte_q == `FISC_CMD_READ_BYTE) begin
              state_q <= FISC_S_FETCH;
            end else if (wbyte_q == `FISC_CMD_WRITE_BYTE) begin
              fl_we_q <= 1'b1;
              fl_wdata_q <= write_data_byte_q;
              state_q <= FISC_S_PROG;
            end else if (wbyte_q == `FISC_CMD_BLOCK_READ) begin
              if (transfer_count_q != 8'h00) begin
                state_q <= FISC_S_FETCH;
              end
            end else if (wbyte_q == `FISC_CMD_BLOCK_WRITE) begin
              if (transfer_count_q != 8'h00) begin
                ram_re <= 1'b1;
                ram_addr <= {segment_q, xptr_q};
                state_q <= FISC_S_LOAD;
              end
            end else if (wbyte_q == `FISC_CMD_MASS_ERASE) begin
              fa_q <= '0;
              state_q <= FISC_S_ERASE;
            end else begin
              sys_reset_req <= 1'b1;
            end
          end
        end
        FISC_S_FETCH: begin
          state_q <= FISC_S_STORE;
        end
        FISC_S_STORE: begin
          if (cmd_q == `FISC_CMD_READ_BYTE) begin
            read_data_byte_q <= fl_rdata;
            state_q <= FISC_S_IDLE;
          end else begin
            ram_we <= 1'b1;
            ram_addr <= {segment_q, ptr_q};
            ram_wdata <= fl_rdata;
            ptr_q <= ptr_q + 8'h01;
            fa_q <= fa_q + 1'b1;
            cnt_q <= cnt_q - 8'h01;
            state_q <= (cnt_q == 8'h01) ? FISC_S_IDLE
                                        : FISC_S_FETCH;
          end
        end
        FISC_S_LOAD: begin
          state_q <= FISC_S_GRAB;
        end
        FISC_S_GRAB: begin
          fl_we_q <= 1'b1;
          fl_wdata_q <= ram_rdata;
          state_q <= FISC_S_PROG;
        end
        FISC_S_PROG: begin
          if (prog_tick) begin
            if (cmd_q == `FISC_CMD_BLOCK_WRITE && cnt_q != 8'h01) begin
              cnt_q <= cnt_q - 8'h01;
              fa_q <= fa_q + 1'b1;
              ptr_q <= ptr_q + 8'h01;
              ram_re <= 1'b1;
              ram_addr <= {segment_q, ptr_q + 8'h01};
              state_q <= FISC_S_LOAD;
            end else begin
              state_q <= FISC_S_IDLE;
            end
          end
        end
        FISC_S_ERASE: begin
          fl_we_q <= 1'b1;
          fl_wdata_q <= `FISC_ERASED_BYTE;
          if (fl_we_q) begin
            fa_q <= fa_q + 1'b1;
            if (fa_q == FLASH_AW'(FLASH_DEPTH - 1)) begin
              fl_we_q <= 1'b0;
              state_q <= FISC_S_IDLE;
            end
          end
        end
        default: state_q <= FISC_S_IDLE;
      endcase
    end
  end

  // busy flag, high from the command edge until back in idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
    end else begin
      busy <= (cmd_go && !bad_cmd && wbyte_q != `FISC_CMD_EXIT &&
               !((wbyte_q == `FISC_CMD_BLOCK_READ ||
                  wbyte_q == `FISC_CMD_BLOCK_WRITE) &&
                 transfer_count_q == 8'h00)) ||
              (state_q != FISC_S_IDLE &&
               !(state_q == FISC_S_STORE &&
                 (cmd_q == `FISC_CMD_READ_BYTE || cnt_q == 8'h01)) &&
               !(state_q == FISC_S_PROG && prog_tick &&
                 !(cmd_q == `FISC_CMD_BLOCK_WRITE && cnt_q != 8'h01)) &&
               !(state_q == FISC_S_ERASE && fl_we_q &&
                 fa_q == FLASH_AW'(FLASH_DEPTH - 1)));
    end
  end

  // error flag: set by refused commands, write one to clear, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_q <= 1'b0;
    end else if (cmd_refused || (cmd_go && bad_cmd)) begin
      err_q <= 1'b1;
    end else if (err_clr) begin
      err_q <= 1'b0;
    end
  end

  // ========================================================================
  // flash array and program timer
  fisc_flash_mem #(
    .DEPTH(FLASH_DEPTH),
    .AW(FLASH_AW)
  ) u_flash (
    .aclk(aclk),
    .re(state_q == FISC_S_FETCH),
    .we(fl_we_q),
    .addr(fa_q),
    .wdata(fl_wdata_q),
    .rdata(fl_rdata)
  );

  fisc_prog_timer #(
    .CYCLES(`FISC_PROG_CYCLES)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(state_q == FISC_S_PROG),
    .tick(prog_tick)
  );

endmodule

`default_nettype wire

// ==== fisc_ram_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// data ram beside the unit, read data one cycle after the strobe
module fisc_ram_model (
  // clock
  input wire logic aclk,
  // ram port
  input wire logic [15:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_we,
  input wire logic ram_re,
  output logic [7:0] ram_rdata
);
  logic [7:0] mem [0:65535];

  initial ram_rdata = 8'h00;

  // store on the write strobe
  always @(posedge aclk)
    if (ram_we === 1'b1) mem[ram_addr] <= ram_wdata;

  // data holds one cycle only, then turns to garbage so stale reads show
  always @(posedge aclk)
    if (ram_re === 1'b1) ram_rdata <= mem[ram_addr];
    else ram_rdata <= ~ram_rdata;
endmodule

`default_nettype wire

// ==== fisc_isp_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// port checks of the isp command unit
module fisc_isp_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // ram port and status
  input wire logic [15:0] ram_addr,
  input wire logic ram_we,
  input wire logic ram_re,
  input wire logic busy,
  input wire logic sys_reset_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // two ram stores of one block read, one byte apart
  sequence s_store_pair;
    ram_we ##2 ram_we;
  endsequence

  // responses hold until taken, one transfer per channel at a time
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response changed early");
  AST_W_CHAN: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_R_CHAN: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  // ram traffic pacing, reset request pulse
  AST_BLK_STEP: assert property (s_store_pair
    |-> ram_addr[7:0] == $past(ram_addr[7:0], 2) + 8'h01)
    else $error("block read store address not consecutive");
  AST_WE_PULSE: assert property (ram_we |=> !ram_we)
    else $error("ram store strobe longer than one cycle");
  AST_RE_SPACE: assert property (ram_re |=> !ram_re [*8])
    else $error("next ram fetch before byte programmed");
  AST_RAM_BUSY: assert property (ram_re |-> busy && !ram_we)
    else $error("ram fetch while not busy");
  AST_RST_PULSE: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request longer than one cycle");
endmodule

bind fisc_isp_unit fisc_isp_checker u_chk (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .ram_addr, .ram_we, .ram_re, .busy, .sys_reset_req
);

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fisc_consts.svh"

// ==========================================================================
// self-checking bench of the isp command unit
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ram_we, ram_re, busy, sys_reset_req;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [15:0] ram_addr;
  logic [7:0] ram_wdata, ram_rdata;
  logic [7:0] exp_fl [0:1023];
  int err_total = 0, n_compared = 0, rst_seen = 0;

  always #25 aclk = ~aclk;
  // count reset request pulses
  always @(posedge aclk)
    if (sys_reset_req === 1'b1) rst_seen++;

  fisc_isp_unit #(.FLASH_DEPTH(1024), .FLASH_AW(10)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ram_addr, .ram_wdata, .ram_we,
    .ram_re, .ram_rdata, .busy, .sys_reset_req
  );
  fisc_ram_model u_ram (.aclk, .ram_addr, .ram_wdata, .ram_we, .ram_re,
    .ram_rdata);

  // ========================================================================
  // reporting
  task automatic stop_test();
    $display("compared %0d, unexpected %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic fail(input string m);
    err_total++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic hang();
    fail("wait ran out");
    stop_test();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) fail($sformatf("data %h, wanted %h", g, e));
  endtask
  task automatic chk_rsp(input logic [1:0] g, input logic [1:0] e);
    n_compared++;
    if (g !== e) fail($sformatf("resp %b, wanted %b", g, e));
  endtask
  // flash byte index from the two address bytes
  function automatic logic [9:0] fl_idx(input logic [7:0] h,
    input logic [7:0] l);
    return {h[1:0], l};
  endfunction

  // ========================================================================
  // bus cycles
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'($urandom); // a late bready makes the response wait
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && s_axi_bready) break;
      if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
    end
    if (n == 100) hang();
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($urandom); // a late rready makes the data wait
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && s_axi_rready) break;
      if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
    end
    if (n == 100) hang();
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic poll();
    int n;
    for (n = 0; n < 2000; n++) begin
      axr(`FISC_OFS_STATUS);
      if (rd[`FISC_ST_BUSY] === 1'b0) break;
    end
    if (n == 2000) hang();
  endtask
  task automatic cmd(input logic [7:0] c);
    axw(`FISC_OFS_COMMAND, {24'h0, c});
    poll();
  endtask
  task automatic set_addr(input logic [7:0] h, input logic [7:0] l);
    axw(`FISC_OFS_ADDR_HIGH, {24'h0, h});
    axw(`FISC_OFS_ADDR_LOW, {24'h0, l});
  endtask

  // ========================================================================
  // main sequence
  initial begin
    int i;
    logic [7:0] hi, lo, d, seg, xp;
    i = $urandom(32'hc7969be1);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // unmapped and misaligned offsets
    axr(8'h28);
    chk_rsp(rsp, `FISC_RESP_SLVERR);
    chk(rd, 32'h0);
    axw(8'h02, 32'h5a);
    chk_rsp(rsp, `FISC_RESP_SLVERR);
    $display("test bus_map done");
    // over-long block write, wrong key, unknown code: flagged, ignored
    axw(`FISC_OFS_COUNT, 32'd17);
    axw(`FISC_OFS_ACCUM, 32'h54);
    for (i = 0; i < 3; i++) begin
      cmd(i == 0 ? `FISC_CMD_BLOCK_WRITE :
        i == 1 ? `FISC_CMD_MASS_ERASE : 8'h77);
      axr(`FISC_OFS_STATUS);
      chk(rd, 32'h2);
      axw(`FISC_OFS_STATUS, 32'h2);
    end
    axr(`FISC_OFS_STATUS);
    chk(rd, 32'h0);
    $display("test refusals done");
    // keyed erase, then random byte program and read back
    axw(`FISC_OFS_ACCUM, {24'h0, `FISC_ERASE_KEY});
    cmd(`FISC_CMD_MASS_ERASE);
    for (i = 0; i < 1024; i++) exp_fl[i] = `FISC_ERASED_BYTE;
    for (i = 0; i < 4; i++) begin
      hi = 8'($urandom_range(3));
      lo = 8'($urandom);
      d = 8'($urandom);
      set_addr(hi, lo);
      cmd(`FISC_CMD_READ_BYTE);
      axr(`FISC_OFS_READ_DATA);
      chk(rd, {24'h0, exp_fl[fl_idx(hi, lo)]});
      axw(`FISC_OFS_WRITE_DATA, {24'h0, d});
      axw(`FISC_OFS_COMMAND, {24'h0, `FISC_CMD_WRITE_BYTE});
      if (i == 0) begin
        axw(`FISC_OFS_COMMAND, {24'h0, `FISC_CMD_READ_BYTE});
        chk_rsp(rsp, `FISC_RESP_SLVERR);
      end
      poll();
      exp_fl[fl_idx(hi, lo)] = d;
      cmd(`FISC_CMD_READ_BYTE);
      axr(`FISC_OFS_READ_DATA);
      chk(rd, {24'h0, d});
    end
    axr(`FISC_OFS_STATUS);
    chk(rd, 32'h2);
    axw(`FISC_OFS_STATUS, 32'h2);
    $display("test bytes done");
    // full 16-byte block write from ram, inside one 32-byte region
    seg = 8'($urandom);
    xp = 8'($urandom_range(224));
    lo = {3'($urandom), 5'h00};
    for (i = 0; i < 16; i++) u_ram.mem[{seg, xp + 8'(i)}] = 8'($urandom);
    set_addr(8'h01, lo);
    axw(`FISC_OFS_COUNT, 32'd16);
    axw(`FISC_OFS_XPTR, {24'h0, xp});
    axw(`FISC_OFS_SEGMENT, {24'h0, seg});
    cmd(`FISC_CMD_BLOCK_WRITE);
    for (i = 0; i < 16; i++)
      exp_fl[fl_idx(8'h01, lo + 8'(i))] = u_ram.mem[{seg, xp + 8'(i)}];
    // zero count programs nothing: the altered source byte must stay out
    u_ram.mem[{seg, xp}] = ~u_ram.mem[{seg, xp}];
    axw(`FISC_OFS_COUNT, 32'h0);
    cmd(`FISC_CMD_BLOCK_WRITE);
    axr(`FISC_OFS_STATUS);
    chk(rd, 32'h0);
    $display("test block_write done");
    // block read: zero count moves nothing, 255 stops short of the last
    seg = seg ^ 8'h80;
    u_ram.mem[{seg, 8'h00}] = 8'h3c;
    u_ram.mem[{seg, 8'hff}] = 8'hc3;
    set_addr(8'h01, 8'h00);
    axw(`FISC_OFS_XPTR, 32'h0);
    axw(`FISC_OFS_SEGMENT, {24'h0, seg});
    axw(`FISC_OFS_COUNT, 32'h0);
    cmd(`FISC_CMD_BLOCK_READ);
    chk({24'h0, u_ram.mem[{seg, 8'h00}]}, 32'h3c);
    axw(`FISC_OFS_COUNT, 32'd255);
    cmd(`FISC_CMD_BLOCK_READ);
    for (i = 0; i < 256; i++)
      chk({24'h0, u_ram.mem[{seg, 8'(i)}]}, {24'h0, i == 255 ? 8'hc3 :
        exp_fl[fl_idx(8'h01, 8'(i))]});
    $display("test block_read done");
    // exit gives exactly one reset request
    rst_seen = 0;
    axw(`FISC_OFS_COMMAND, {24'h0, `FISC_CMD_EXIT});
    repeat (4) @(posedge aclk);
    chk(32'(rst_seen), 32'h1);
    $display("test exit done");
    stop_test();
  end
endmodule

`default_nettype wire
